// [rtl/bsr_top.sv]
`default_nettype none

module bsr_top #(
  parameter int unsigned NB = bsr_pkg::NUM_BUCKS
) (
  input  wire logic           mclk_i,
  input  wire logic           rst_i,
  input  wire logic           ce_i,
  input  wire logic [1:0]     pmic_state_i,
  input  wire logic           processor_reset_out_n_i,
  input  wire logic [NB*6-1:0] factory_voltage_code_i,
  input  wire logic [NB-1:0]  factory_scaling_select_i,
  input  wire logic           reg_wr_i,
  input  wire logic           reg_rd_i,
  input  wire logic [$clog2(NB)-1:0] reg_buck_i,
  input  wire logic [1:0]     reg_sel_i,
  input  wire logic [5:0]     reg_wdata_i,
  output logic      [5:0]     reg_rdata_o,
  output logic                reg_ack_o,
  output logic                reg_err_o,
  output logic      [NB*6-1:0] target_code_o,
  output logic      [NB*16-1:0] target_volt_o,
  output logic                target_valid_o,
  output logic      [NB-1:0]  scaling_select_o
);

  bsr_pkg::bsr_state_e state;
  bsr_pkg::bsr_state_e next_state;

  logic [5:0]       run_sp      [NB];
  logic [5:0]       stby_sp     [NB];
  logic [5:0]       slp_sp      [NB];
  logic [5:0]       next_run_sp [NB];
  logic [5:0]       next_stby_sp[NB];
  logic [5:0]       next_slp_sp [NB];
  logic [NB-1:0]    sel_latch;
  logic [NB-1:0]    next_sel_latch;
  logic [5:0]       next_rdata;
  logic             next_ack;
  logic             next_err;
  logic [NB*6-1:0]  next_target_code;
  logic [NB*16-1:0] next_target_volt;
  logic             next_target_valid;
  logic [15:0]      dec_volt    [NB];
  logic [5:0]       chosen_code [NB];

  // Field widths of one buck inside the packed ports
  localparam int unsigned CW = bsr_pkg::CODE_W;
  localparam int unsigned VW = bsr_pkg::MV_W;

  // Setpoint picked by chip state
  function automatic logic [5:0] pick_sp(input logic [1:0] pst, input logic [5:0] r,
                                         input logic [5:0] s, input logic [5:0] l);
    logic [5:0] c;
    c = r;
    case (pst)
      bsr_pkg::PMIC_STBY: c = s;
      bsr_pkg::PMIC_SLP:  c = l;
      default:            c = r;
    endcase
    return c;
  endfunction

  // Write gate: live state, reset released, scaling enabled for that buck
  function automatic logic wr_allowed(input bsr_pkg::bsr_state_e st, input logic rel,
                                      input logic sel);
    return (st == bsr_pkg::BSR_ST_ACTIVE) && rel && (sel == bsr_pkg::DVS_ON);
  endfunction

  // Select and buck index both name a real setpoint
  function automatic logic in_range(input logic [1:0] s, input logic [$clog2(NB)-1:0] b);
    return (s <= bsr_pkg::SEL_SLP) && (32'(b) < NB);
  endfunction

  generate
    for (genvar g = 0; g < NB; g++) begin : g_buck
      always_comb begin
        chosen_code[g] = pick_sp(pmic_state_i, run_sp[g], stby_sp[g], slp_sp[g]);
      end
      bsr_decode u_dec (
        .code_i           (chosen_code[g]),
        .scaling_select_i (sel_latch[g]),
        .volt_o           (dec_volt[g])
      );
    end
  endgenerate

  always_comb begin
    next_state        = state;
    next_sel_latch    = sel_latch;
    next_rdata        = reg_rdata_o;
    next_ack          = 1'b0;
    next_err          = 1'b0;
    next_target_code  = target_code_o;
    next_target_volt  = target_volt_o;
    next_target_valid = 1'b0;
    for (int b = 0; b < NB; b++) begin
      next_run_sp[b]  = run_sp[b];
      next_stby_sp[b] = stby_sp[b];
      next_slp_sp[b]  = slp_sp[b];
    end

    case (state)
      bsr_pkg::BSR_ST_OFF: begin
        if (pmic_state_i == bsr_pkg::PMIC_RUN) begin
          next_state = bsr_pkg::BSR_ST_ACTIVE;
          // Mode is caught only here and held until the next power-up
          next_sel_latch = factory_scaling_select_i;
          for (int b = 0; b < NB; b++) begin
            next_run_sp[b]  = factory_voltage_code_i[b*CW +: CW];
            next_stby_sp[b] = factory_voltage_code_i[b*CW +: CW];
            next_slp_sp[b]  = factory_voltage_code_i[b*CW +: CW];
          end
        end
      end
      bsr_pkg::BSR_ST_ACTIVE: begin
        if (pmic_state_i == bsr_pkg::PMIC_OFF) begin
          next_state = bsr_pkg::BSR_ST_OFF;
        end
      end
      default: begin
        next_state = bsr_pkg::BSR_ST_OFF;
      end
    endcase

    // Register access; a write touches only the addressed buck
    if (reg_wr_i || reg_rd_i) begin
      next_ack = 1'b1;
      if (!in_range(reg_sel_i, reg_buck_i)) begin
        next_err   = 1'b1;
        next_rdata = bsr_pkg::CODE_RST;
      end else if (reg_rd_i) begin
        case (reg_sel_i)
          bsr_pkg::SEL_STBY: next_rdata = stby_sp[reg_buck_i];
          bsr_pkg::SEL_SLP:  next_rdata = slp_sp[reg_buck_i];
          default:           next_rdata = run_sp[reg_buck_i];
        endcase
      end else if (!wr_allowed(state, processor_reset_out_n_i, sel_latch[reg_buck_i])) begin
        next_err = 1'b1;
      end else begin
        case (reg_sel_i)
          bsr_pkg::SEL_STBY: next_stby_sp[reg_buck_i] = reg_wdata_i;
          bsr_pkg::SEL_SLP:  next_slp_sp[reg_buck_i]  = reg_wdata_i;
          default:           next_run_sp[reg_buck_i]  = reg_wdata_i;
        endcase
      end
    end

    // Regulator targets, valid only while powered
    if (state == bsr_pkg::BSR_ST_ACTIVE && pmic_state_i != bsr_pkg::PMIC_OFF) begin
      next_target_valid = 1'b1;
      for (int b = 0; b < NB; b++) begin
        next_target_code[b*CW +: CW] = chosen_code[b];
        next_target_volt[b*VW +: VW] = dec_volt[b];
      end
    end else begin
      next_target_code = '0;
      next_target_volt = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state          <= bsr_pkg::BSR_ST_OFF;
      sel_latch      <= '0;
      target_code_o  <= '0;
      target_volt_o  <= '0;
      target_valid_o <= 1'b0;
      for (int b = 0; b < NB; b++) begin
        run_sp[b]  <= bsr_pkg::CODE_RST;
        stby_sp[b] <= bsr_pkg::CODE_RST;
        slp_sp[b]  <= bsr_pkg::CODE_RST;
      end
    end else if (ce_i) begin
      state          <= next_state;
      sel_latch      <= next_sel_latch;
      target_code_o  <= next_target_code;
      target_volt_o  <= next_target_volt;
      target_valid_o <= next_target_valid;
      for (int b = 0; b < NB; b++) begin
        run_sp[b]  <= next_run_sp[b];
        stby_sp[b] <= next_stby_sp[b];
        slp_sp[b]  <= next_slp_sp[b];
      end
    end
  end

  // Register port answer, one cycle after the request
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      reg_rdata_o <= bsr_pkg::CODE_RST;
      reg_ack_o   <= 1'b0;
      reg_err_o   <= 1'b0;
    end else if (ce_i) begin
      reg_rdata_o <= next_rdata;
      reg_ack_o   <= next_ack;
      reg_err_o   <= next_err;
    end
  end

  always_comb begin
    scaling_select_o = sel_latch;
  end

endmodule

`default_nettype wire

// [shared/bsr_pkg.sv]
`default_nettype none

package bsr_pkg;

  // Regulator instances and code width
  localparam int unsigned NUM_BUCKS = 2;
  localparam int unsigned CODE_W    = 6;
  localparam int unsigned MV_W      = 16;

  // Setpoint register selects on the register access port
  localparam logic [1:0] SEL_RUN   = 2'h0;
  localparam logic [1:0] SEL_STBY  = 2'h1;
  localparam logic [1:0] SEL_SLP   = 2'h2;

  // Chip operating state as delivered by the power sequencer
  localparam logic [1:0] PMIC_OFF  = 2'h0;
  localparam logic [1:0] PMIC_RUN  = 2'h1;
  localparam logic [1:0] PMIC_STBY = 2'h2;
  localparam logic [1:0] PMIC_SLP  = 2'h3;

  // Scaling select values
  localparam logic DVS_ON  = 1'h0;
  localparam logic DVS_OFF = 1'h1;

  // Reset values
  localparam logic [5:0]  CODE_RST = 6'h00;
  localparam logic [15:0] VOLT_RST = 16'h0000;

  // Voltages in units of 100 uV
  localparam logic [15:0] DVS_BASE = 16'h1770;
  localparam logic [15:0] DVS_STEP = 16'h007d;
  localparam logic [2:0]  FIXED_LAST = 3'h7;
  localparam logic [15:0] FIXED_V0 = 16'h2af8;
  localparam logic [15:0] FIXED_V1 = 16'h2ee0;
  localparam logic [15:0] FIXED_V2 = 16'h34bc;
  localparam logic [15:0] FIXED_V3 = 16'h3a98;
  localparam logic [15:0] FIXED_V4 = 16'h4650;
  localparam logic [15:0] FIXED_V5 = 16'h61a8;
  localparam logic [15:0] FIXED_V6 = 16'h7530;
  localparam logic [15:0] FIXED_V7 = 16'h80e8;

  typedef enum logic [1:0] {
    BSR_ST_OFF    = 2'b00,
    BSR_ST_ACTIVE = 2'b01
  } bsr_state_e;

endpackage

`default_nettype wire

// [rtl/bsr_decode.sv]
`default_nettype none

module bsr_decode (
  input  wire logic [5:0]  code_i,
  input  wire logic        scaling_select_i,
  output logic      [15:0] volt_o
);

  // Code to output voltage, 100 uV units
  function automatic logic [15:0] code_to_volt(input logic [5:0] code, input logic sel);
    logic [15:0] v;
    v = bsr_pkg::VOLT_RST;
    if (sel == bsr_pkg::DVS_ON) begin
      v = 16'(bsr_pkg::DVS_BASE + 16'(code) * bsr_pkg::DVS_STEP);
    end else if (code > 6'(bsr_pkg::FIXED_LAST)) begin
      v = bsr_pkg::FIXED_V7;
    end else begin
      case (code[2:0])
        3'h0:    v = bsr_pkg::FIXED_V0;
        3'h1:    v = bsr_pkg::FIXED_V1;
        3'h2:    v = bsr_pkg::FIXED_V2;
        3'h3:    v = bsr_pkg::FIXED_V3;
        3'h4:    v = bsr_pkg::FIXED_V4;
        3'h5:    v = bsr_pkg::FIXED_V5;
        3'h6:    v = bsr_pkg::FIXED_V6;
        default: v = bsr_pkg::FIXED_V7;
      endcase
    end
    return v;
  endfunction

  always_comb begin
    volt_o = code_to_volt(code_i, scaling_select_i);
  end

endmodule

`default_nettype wire

// [tb/bsr_props.sv]
`default_nettype none
module bsr_props #(
  parameter int unsigned NB = 2
) (
  input wire logic                    mclk_i,
  input wire logic                    rst_i,
  input wire logic                    ce_i,
  input wire logic [1:0]              pmic_state_i,
  input wire logic                    processor_reset_out_n_i,
  input wire logic [NB*6-1:0]         factory_voltage_code_i,
  input wire logic [NB-1:0]           factory_scaling_select_i,
  input wire logic                    reg_wr_i,
  input wire logic                    reg_rd_i,
  input wire logic [$clog2(NB)-1:0]   reg_buck_i,
  input wire logic [1:0]              reg_sel_i,
  input wire logic [5:0]              reg_wdata_i,
  input wire logic [5:0]              reg_rdata_o,
  input wire logic                    reg_ack_o,
  input wire logic                    reg_err_o,
  input wire logic [NB*6-1:0]         target_code_o,
  input wire logic [NB*16-1:0]        target_volt_o,
  input wire logic                    target_valid_o,
  input wire logic [NB-1:0]           scaling_select_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic req;
  logic wr;
  logic vok;
  assign req = ce_i && (reg_wr_i || reg_rd_i);
  assign wr = ce_i && reg_wr_i && !reg_rd_i;
  // Expected voltage, 100 uV units
  function automatic logic [15:0] dec(input logic [5:0] c, input logic s);
    logic [15:0] t [8];
    t = '{16'h2af8, 16'h2ee0, 16'h34bc, 16'h3a98, 16'h4650, 16'h61a8, 16'h7530, 16'h80e8};
    if (!s) return 16'h1770 + 16'h007d * {10'h000, c};
    return (c > 6'h07) ? 16'h80e8 : t[c[2:0]];
  endfunction
  always_comb begin
    vok = 1'b1;
    for (int i = 0; i < NB; i++)
      if (target_volt_o[i*16+:16] != dec(target_code_o[i*6+:6], scaling_select_o[i])) vok = 1'b0;
  end
  a_ack_follows_req: assert property (req |=> reg_ack_o)
    else $error("request without ack");
  a_ack_only_req: assert property (reg_ack_o |-> $past(req))
    else $error("ack without request");
  a_load_factory: assert property ($rose(target_valid_o) |->
    target_code_o == $past(factory_voltage_code_i, 2)) else $error("startup code wrong");
  a_write_taken: assert property (wr && target_valid_o && pmic_state_i != 2'h0 &&
    processor_reset_out_n_i && !scaling_select_o[reg_buck_i] && reg_sel_i != 2'h3
    |=> reg_ack_o && !reg_err_o) else $error("legal write refused");
  a_readonly_refuse: assert property (wr && scaling_select_o[reg_buck_i] |=> reg_err_o)
    else $error("read-only write taken");
  a_volt_decode: assert property (target_valid_o |-> vok)
    else $error("voltage decode wrong");
  a_off_no_target: assert property (ce_i && pmic_state_i == 2'h0 |=>
    !target_valid_o && target_code_o == '0) else $error("target while off");
  a_select_fixed: assert property (target_valid_o |-> $stable(scaling_select_o))
    else $error("select changed while running");
  a_other_buck_kept: assert property (wr && target_valid_o && reg_buck_i == '0 &&
    pmic_state_i != 2'h0 ##1 !reg_wr_i && $stable(pmic_state_i)
    |=> $stable(target_code_o[NB*6-1:6])) else $error("other buck disturbed");
  c_startup: cover property ($rose(target_valid_o));
  c_refused: cover property (reg_ack_o && reg_err_o);
  c_sleep: cover property (target_valid_o && pmic_state_i == 2'h3);
endmodule
bind bsr_top bsr_props #(.NB(NB)) u_props (.*);
`default_nettype wire

// [tb/bsr_host.sv]
`default_nettype none
module bsr_host (
  input  wire logic       mclk_i,
  input  wire logic [1:0] ro_i,
  input  wire logic       ack_i,
  input  wire logic       err_i,
  input  wire logic [5:0] rdata_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic            buck_o,
  output logic      [1:0] sel_o,
  output logic      [5:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    buck_o = 1'b0;
    sel_o = 2'h0;
    wdata_o = 6'h00;
  end
  // One request, answer taken one cycle later
  task automatic acc(input logic w, input logic b, input logic [1:0] s,
                     input logic [5:0] d, input logic brk, output logic [7:0] ans);
    @(negedge mclk_i);
    wr_o <= w & (brk | !ro_i[b]);
    rd_o <= !w;
    buck_o <= b;
    sel_o <= s;
    wdata_o <= d;
    @(negedge mclk_i);
    ans = {ack_i, err_i, rdata_i};
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    wdata_o <= ~d;
  endtask
endmodule
`default_nettype wire

// [tb/bsr_top_tb.sv]
`default_nettype none
module bsr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i;
  logic        rst_i;
  logic [1:0]  pst;
  logic        prn;
  logic [11:0] fcode;
  logic [1:0]  fsel;
  logic        wr;
  logic        rd;
  logic        bk;
  logic [1:0]  sel;
  logic [5:0]  wd;
  logic [5:0]  rdata;
  logic        ack;
  logic        err;
  logic [11:0] tcode;
  logic [31:0] tvolt;
  logic        tval;
  logic [1:0]  ssel;
  logic [7:0]  ans;
  int          error_cnt = 0;
  int          checked = 0;
  logic [15:0] fx [9] = '{16'h2af8, 16'h2ee0, 16'h34bc, 16'h3a98, 16'h4650, 16'h61a8,
                          16'h7530, 16'h80e8, 16'h80e8};
  logic [5:0]  sp [3] = '{6'h3f, 6'h00, 6'h2a};
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  bsr_top #(.NB(2)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1), .pmic_state_i(pst),
    .processor_reset_out_n_i(prn), .factory_voltage_code_i(fcode),
    .factory_scaling_select_i(fsel), .reg_wr_i(wr), .reg_rd_i(rd), .reg_buck_i(bk),
    .reg_sel_i(sel), .reg_wdata_i(wd), .reg_rdata_o(rdata), .reg_ack_o(ack),
    .reg_err_o(err), .target_code_o(tcode), .target_volt_o(tvolt),
    .target_valid_o(tval), .scaling_select_o(ssel));
  bsr_host host (.mclk_i(mclk_i), .ro_i(ssel), .ack_i(ack), .err_i(err), .rdata_i(rdata),
    .wr_o(wr), .rd_o(rd), .buck_o(bk), .sel_o(sel), .wdata_o(wd));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic go(input logic w, input logic b, input logic [1:0] s, input logic [5:0] d,
                    input logic brk);
    host.acc(w, b, s, d, brk, ans);
  endtask
  initial begin
    #20000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    rst_i = 1'b1;
    pst = 2'h0;
    prn = 1'b0;
    fcode = 12'h0c5;
    fsel = 2'h2;
    cyc(4);
    rst_i = 1'b0;
    go(1'b1, 1'b0, 2'h0, 6'h11, 1'b0);
    chk(ans[7:6], 2'h3, "write while off");
    pst = 2'h1;
    cyc(2);
    chk(tcode, 12'h0c5, "startup code");
    chk(tval, 1'b1, "target valid");
    chk(tvolt[15:0], 16'h19e1, "scaled volt");
    chk(tvolt[31:16], 16'h3a98, "fixed volt");
    for (int i = 0; i < 6; i++) begin
      go(1'b0, i[0], i[2:1], 6'h00, 1'b0);
      chk(ans[5:0], i[0] ? 6'h03 : 6'h05, "loaded setpoint");
    end
    go(1'b1, 1'b0, 2'h0, 6'h3f, 1'b0);
    chk(ans[7:6], 2'h3, "write in proc reset");
    prn = 1'b1;
    for (int i = 0; i < 3; i++) begin
      go(1'b1, 1'b0, 2'(i), sp[i], 1'b0);
      chk(ans[7:6], 2'h2, "write taken");
    end
    chk(tcode[11:6], 6'h03, "other buck");
    go(1'b1, 1'b1, 2'h0, 6'h3c, 1'b1);
    chk(ans[7:6], 2'h3, "read-only write");
    go(1'b0, 1'b1, 2'h0, 6'h00, 1'b0);
    chk(ans[5:0], 6'h03, "read-only kept");
    go(1'b0, 1'b0, 2'h3, 6'h00, 1'b0);
    chk(ans[6:0], 7'h40, "unmapped read");
    for (int i = 0; i < 3; i++) begin
      pst = 2'(i + 1);
      cyc(2);
      chk(tcode[5:0], sp[i], "state code");
      chk(tvolt[15:0], 16'h1770 + 16'h007d * sp[i], "state volt");
    end
    for (int c = 0; c < 9; c++) begin
      pst = 2'h0;
      fcode[11:6] = 6'(c);
      cyc(2);
      chk(tval, 1'b0, "valid while off");
      pst = 2'h1;
      cyc(2);
      chk(tvolt[31:16], fx[c], "table volt");
      fsel = 2'h1;
      cyc(1);
      chk(ssel, 2'h2, "select held");
      fsel = 2'h2;
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
